// >>> sim/host_line_model.sv
// host side of the shared open-drain motion line
`timescale 1ns/100ps
module host_line_model (
	// clock
	input  wire logic ref_clk,
	// host controls and device pull-down
	input  wire logic pull_en,
	input  wire logic drive_low,
	input  wire logic dev_oe,
	// resolved line
	output logic      line
);
	logic float_reg = 1'b0;
	// no pull-up: a floating line is noise, never a held level
	always @(posedge ref_clk) float_reg <= !float_reg;
	always_comb begin
		if (drive_low || dev_oe) line = 1'b0;
		else if (pull_en) line = 1'b1;
		else line = float_reg;
	end
endmodule

// >>> sim/power_mode_and_one_wire_wake_props.sv
// port assertions for the mode sequencer
`timescale 1ns/100ps
module power_mode_and_one_wire_wake_props #(
	parameter int PULSE_CYCLES = 20,
	parameter int HIB_CYCLES   = 50,
	parameter int MOT_CYCLES   = 20
) (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       clk_en,
	// watched ports
	input wire logic       boot_select_pin,
	input wire logic       motion_line_in,
	input wire logic       meas_done,
	input wire logic       motion_line_oe,
	input wire logic       active_bit,
	input wire logic       conv_start,
	input wire logic [6:0] mode_state
);
	logic [31:0] oe_run_reg;
	logic [31:0] low_run_reg;
	// run lengths, frozen with clk_en like the design
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			oe_run_reg  <= '0;
			low_run_reg <= '0;
		end else if (clk_en) begin
			oe_run_reg  <= motion_line_oe ? oe_run_reg + 32'h1 : 32'h0;
			low_run_reg <= motion_line_in ? 32'h0 : low_run_reg + 32'h1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_conv_one; conv_start |=> !conv_start; endproperty
	a_conv_one: assert property (p_conv_one) else $error("conv_start too long");
	property p_conv_meas; conv_start |-> ##[0:1] mode_state == power_mode_pkg::ST_MEAS; endproperty
	a_conv_meas: assert property (p_conv_meas) else $error("no measure state");
	property p_meas_back;
		mode_state == power_mode_pkg::ST_MEAS && meas_done && clk_en
			|-> ##[1:3] mode_state == power_mode_pkg::ST_TRIG;
	endproperty
	a_meas_back: assert property (p_meas_back) else $error("no return to trigger");
	property p_no_trig; boot_select_pin |-> mode_state != power_mode_pkg::ST_TRIG; endproperty
	a_no_trig: assert property (p_no_trig) else $error("trigger state with strap high");
	property p_oe_len;
		$fell(motion_line_oe) |-> oe_run_reg == PULSE_CYCLES || oe_run_reg == MOT_CYCLES;
	endproperty
	a_oe_len: assert property (p_oe_len) else $error("pulse length wrong");
	property p_hib_debounce;
		$rose(mode_state == power_mode_pkg::ST_HIB) && boot_select_pin
			&& $past(mode_state) != power_mode_pkg::ST_BOOT |-> low_run_reg >= HIB_CYCLES;
	endproperty
	a_hib_debounce: assert property (p_hib_debounce) else $error("early hibernate");
	property p_hib_inactive; (mode_state == power_mode_pkg::ST_HIB)[*2] |-> !active_bit; endproperty
	a_hib_inactive: assert property (p_hib_inactive) else $error("active in hibernate");
	property p_wake_active;
		$rose(mode_state == power_mode_pkg::ST_WAKE) |-> ##[0:1] active_bit;
	endproperty
	a_wake_active: assert property (p_wake_active) else $error("wake without active");
	property p_hib_exit;
		(mode_state == power_mode_pkg::ST_HIB && boot_select_pin && motion_line_in)[*3]
			|-> ##[0:2] mode_state == power_mode_pkg::ST_BOOT;
	endproperty
	a_hib_exit: assert property (p_hib_exit) else $error("no exit on line high");
endmodule
bind power_mode_and_one_wire_wake power_mode_and_one_wire_wake_props #(
	.PULSE_CYCLES(PULSE_CYCLES), .HIB_CYCLES(HIB_CYCLES), .MOT_CYCLES(MOT_CYCLES)
) u_props (
	.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .boot_select_pin(boot_select_pin),
	.motion_line_in(motion_line_in), .meas_done(meas_done), .motion_line_oe(motion_line_oe),
	.active_bit(active_bit), .conv_start(conv_start), .mode_state(mode_state)
);

// >>> sim/power_mode_and_one_wire_wake_tb.sv
// self-checking bench for the mode sequencer
`timescale 1ns/100ps
module power_mode_and_one_wire_wake_tb;
	logic        ref_clk, nrst, clk_en, boot_select_pin, motion_line_in, motion_line_out;
	logic        motion_line_oe, second_interrupt_pin, wake_pin, active_wr, active_wr_val, hib_wr;
	logic        pin_two_function_select, auto_wake_sleep_event, meas_done, motion_detected;
	logic        sample_tick, active_bit, conv_start, sample_enable, serial_enable;
	logic        pull_en, drive_low, oe_last;
	logic [15:0] auto_sleep_count;
	logic [1:0]  threshold_code;
	logic [6:0]  mode_state;
	logic [6:0]  exp_q[$];
	int          fails, num_checks, seed, oe_rises;
	power_mode_and_one_wire_wake #(.BOOT_CYCLES(40), .PULSE_CYCLES(20), .WIN_CYCLES(100),
		.HIB_CYCLES(50), .MOT_CYCLES(20)) u_dut (.ref_clk, .nrst, .clk_en, .boot_select_pin,
		.motion_line_in, .motion_line_out, .motion_line_oe, .second_interrupt_pin, .wake_pin,
		.active_wr, .active_wr_val, .hib_wr, .pin_two_function_select, .auto_sleep_count,
		.auto_wake_sleep_event, .meas_done, .motion_detected, .sample_tick, .active_bit,
		.conv_start, .sample_enable, .serial_enable, .threshold_code, .mode_state);
	host_line_model u_host (.ref_clk, .pull_en, .drive_low, .dev_oe(motion_line_oe),
		.line(motion_line_in));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic wait_mode(input logic [6:0] m);
		for (int i = 0; i < 3000; i++) begin
			@(posedge ref_clk);
			#1;
			if (mode_state === m) return;
		end
		chk("mode wait", m, mode_state);
		finish_test();
	endtask
	task automatic do_reset(input logic strap);
		@(posedge ref_clk);
		nrst <= 1'b0;
		boot_select_pin <= strap;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
	endtask
	task automatic wr_active(input logic v);
		@(posedge ref_clk);
		active_wr <= 1'b1;
		active_wr_val <= v;
		@(posedge ref_clk);
		active_wr <= 1'b0;
	endtask
	// sample ticks arrive irregularly, as a real rate divider would not
	always @(posedge ref_clk) sample_tick <= $random(seed) & 1;
	always @(posedge ref_clk) begin
		if (motion_line_oe === 1'b1 && oe_last !== 1'b1) oe_rises++;
		oe_last = motion_line_oe;
	end
	// each conversion start must match a trigger noted by the driver
	always @(negedge ref_clk) begin
		if (conv_start === 1'b1) begin
			if (exp_q.size() == 0) chk("unexpected conv", 7'h00, 7'h7f);
			else chk("state after conv", exp_q.pop_front(), mode_state);
		end
	end
	initial begin
		{nrst, boot_select_pin, second_interrupt_pin, wake_pin, active_wr, active_wr_val} = '0;
		{hib_wr, pin_two_function_select, auto_wake_sleep_event, meas_done} = '0;
		{motion_detected, drive_low, auto_sleep_count} = '0;
		{clk_en, pull_en} = 2'h3;
		{fails, num_checks, oe_rises} = '0;
		seed = 40548;
		do_reset(1'b0);
		wait_mode(power_mode_pkg::ST_STANDBY);
		wr_active(1'b1);
		wait_mode(power_mode_pkg::ST_WAKE);
		auto_sleep_count <= 16'h0003;
		wait_mode(power_mode_pkg::ST_SLEEP);
		@(posedge ref_clk);
		auto_wake_sleep_event <= 1'b1;
		auto_sleep_count <= 16'h0000;
		@(posedge ref_clk);
		auto_wake_sleep_event <= 1'b0;
		wait_mode(power_mode_pkg::ST_WAKE);
		wr_active(1'b0);
		wait_mode(power_mode_pkg::ST_STANDBY);
		chk("active", 7'h00, {6'h0, active_bit});
		clk_en <= 1'b0;
		pin_two_function_select <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk("frozen", power_mode_pkg::ST_STANDBY, mode_state);
		clk_en <= 1'b1;
		wait_mode(power_mode_pkg::ST_TRIG);
		for (int k = 0; k < 3; k++) begin
			exp_q.push_back(power_mode_pkg::ST_MEAS);
			repeat (2 + ($random(seed) & 7)) @(posedge ref_clk);
			second_interrupt_pin <= 1'b1;
			wait_mode(power_mode_pkg::ST_MEAS);
			@(posedge ref_clk);
			meas_done <= 1'b1;
			@(posedge ref_clk);
			meas_done <= 1'b0;
			second_interrupt_pin <= 1'b0;
			wait_mode(power_mode_pkg::ST_TRIG);
		end
		chk("pending conv", 7'h00, 7'(exp_q.size()));
		pin_two_function_select <= 1'b0;
		wait_mode(power_mode_pkg::ST_STANDBY);
		hib_wr <= 1'b1;
		@(posedge ref_clk);
		hib_wr <= 1'b0;
		wait_mode(power_mode_pkg::ST_HIB);
		repeat (20) @(posedge ref_clk);
		chk("hib hold", power_mode_pkg::ST_HIB, mode_state);
		wake_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		wake_pin <= 1'b0;
		wait_mode(power_mode_pkg::ST_STANDBY);
		pull_en <= 1'b0;
		drive_low <= 1'b1;
		oe_rises = 0;
		do_reset(1'b1);
		wait_mode(power_mode_pkg::ST_HIB);
		chk("boot pulses", 7'h01, oe_rises[6:0]);
		chk("active", 7'h00, {6'h0, active_bit});
		drive_low <= 1'b0;
		pull_en <= 1'b1;
		wait_mode(power_mode_pkg::ST_BOOT);
		wait_mode(power_mode_pkg::ST_WAKE);
		drive_low <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk("active", 7'h01, {6'h0, active_bit});
		chk("serial", 7'h01, {6'h0, serial_enable});
		chk("sample enable", 7'h01, {6'h0, sample_enable});
		repeat (8) @(posedge ref_clk);
		drive_low <= 1'b0;
		repeat (120) @(posedge ref_clk);
		chk("threshold", 7'h00, {5'h0, threshold_code});
		chk("short low", power_mode_pkg::ST_WAKE, mode_state);
		motion_detected <= 1'b1;
		for (int i = 0; i < 200 && motion_line_oe !== 1'b1; i++) @(posedge ref_clk);
		motion_detected <= 1'b0;
		#1;
		chk("motion line", 7'h00, {6'h0, motion_line_in});
		chk("line out level", 7'h00, {6'h0, motion_line_out});
		repeat (40) @(posedge ref_clk);
		pin_two_function_select <= 1'b1;
		second_interrupt_pin <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk("no trigger", power_mode_pkg::ST_WAKE, mode_state);
		wr_active(1'b0);
		wait_mode(power_mode_pkg::ST_STANDBY);
		wr_active(1'b1);
		wait_mode(power_mode_pkg::ST_WAKE);
		drive_low <= 1'b1;
		wait_mode(power_mode_pkg::ST_HIB);
		repeat (2) @(posedge ref_clk);
		chk("active", 7'h00, {6'h0, active_bit});
		finish_test();
	end
endmodule

// >>> verilog/power_mode_and_one_wire_wake.sv
// operating mode sequencer with one-wire motion protocol
// Behaviour
// (RQ1) boot-select low, trigger mode: trigger rising edge starts one conversion, enters measure state.
// (RQ2) boot-select high: external-trigger state is never entered or left.
// (RQ3) after triggered measurement completes, return to trigger state automatically.
// (RQ4) boot-select low: active bit one goes standby to wake, zero back.
// (RQ5) boot-select high: active bit set by itself after boot with line high.
// (RQ6) boot-select high: host may set active bit again to resume detection.
// (RQ7) boot-select high: line low for debounce time clears active; host may too.
// (RQ8) auto-sleep count nonzero and timer expires unrestarted: wake drops to sleep.
// (RQ9) in sleep any enabled wake/sleep event returns device to wake.
// (RQ10) during one-wire boot, drive boot indicator for its pulse duration.
// (RQ11) line still low at end of boot: hibernate, keep line input watched.
// (RQ12) line raised high: leave hibernate and run boot again.
// (RQ13) host may pulse line low inside window after boot indicator ends.
// (RQ14) no pulse in window: default threshold code zero.
// (RQ15) pulse counted only if inside window with width in allowed range.
// (RQ16) on motion detect, pull line low for the motion pulse duration.
// (RQ17) register access stays available during motion detection.
// (RQ18) host holds line low for debounce time to request hibernate.
// (RQ19) boot-select low: hibernate bit enters hibernate; only wake pin toggle exits.
// (RQ20) boot-select low: pin-two function bit enters trigger state, clearing leaves.
// (RQ21) boot-select latched once after reset picks the control path.
`timescale 1ns/100ps
`include "power_mode_cfg.svh"
module power_mode_and_one_wire_wake #(
	parameter int BOOT_CYCLES   = `BOOT_CYCLES,
	parameter int PULSE_CYCLES  = `BOOT_PULSE_CYCLES,
	parameter int WIN_CYCLES    = `WIN_CYCLES,
	parameter int HIB_CYCLES    = `HIB_CYCLES,
	parameter int MOT_CYCLES    = `MOT_PULSE_CYCLES,
	parameter int CNT_W         = 24,
	parameter int ASLP_W        = 16
) (
	// clock, reset, enable
	input  wire logic                ref_clk,
	input  wire logic                nrst,
	input  wire logic                clk_en,
	// pins
	input  wire logic                boot_select_pin,
	input  wire logic                motion_line_in,
	output logic                     motion_line_out,
	output logic                     motion_line_oe,
	input  wire logic                second_interrupt_pin,
	input  wire logic                wake_pin,
	// register-side controls from the serial interface
	input  wire logic                active_wr,
	input  wire logic                active_wr_val,
	input  wire logic                hib_wr,
	input  wire logic                pin_two_function_select,
	input  wire logic [ASLP_W-1:0]   auto_sleep_count,
	input  wire logic                auto_wake_sleep_event,
	input  wire logic                meas_done,
	input  wire logic                motion_detected,
	input  wire logic                sample_tick,
	// status
	output logic                     active_bit,
	output logic                     conv_start,
	output logic                     sample_enable,
	output logic                     serial_enable,
	output logic [1:0]               threshold_code,
	output logic [6:0]               mode_state
);
	power_mode_pkg::mode_t state_reg;
	logic [2:0]       bsel_sync_reg, line_sync_reg, trig_sync_reg, wake_sync_reg;
	logic             strap_reg, strap_done_reg;
	logic             line_s, line_prev_reg, trig_prev_reg, wake_prev_reg;
	logic             active_reg, drive_reg;
	logic [CNT_W-1:0] boot_cnt_reg, hib_cnt_reg, win_cnt_reg, low_cnt_reg, mot_cnt_reg;
	logic             win_open_reg;
	logic [1:0]       thr_reg;
	logic [ASLP_W-1:0] auto_sleep_count_reg;
	logic             trig_rise, wake_toggle, hib_low_done;
	logic             boot_strap, boot_ind, boot_ind_reg;
	// strap pin needs two sync flops before boot logic can trust it
	localparam int IND_OFS = 2;

	// external pins pass two flops; bit 2 is the history for edge detection
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bsel_sync_reg <= 3'h0;
			line_sync_reg <= 3'h0;
			trig_sync_reg <= 3'h0;
			wake_sync_reg <= 3'h0;
		end else if (clk_en) begin
			bsel_sync_reg <= {bsel_sync_reg[1:0], boot_select_pin};
			line_sync_reg <= {line_sync_reg[1:0], motion_line_in};
			trig_sync_reg <= {trig_sync_reg[1:0], second_interrupt_pin};
			wake_sync_reg <= {wake_sync_reg[1:0], wake_pin};
		end
	end
	assign line_s        = line_sync_reg[1];
	assign line_prev_reg = line_sync_reg[2];
	assign trig_prev_reg = trig_sync_reg[2];
	assign wake_prev_reg = wake_sync_reg[2];
	// trigger edge comes from synced copies, so it lags the pin by two cycles
	assign trig_rise     = trig_sync_reg[1] & ~trig_prev_reg;
	assign wake_toggle   = wake_sync_reg[1] ^ wake_prev_reg;

	// strap caught once after release, stays fixed until the next reset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			strap_reg      <= 1'b0;
			strap_done_reg <= 1'b0;
		end else if (clk_en && !strap_done_reg && boot_cnt_reg == CNT_W'(IND_OFS)) begin
			strap_reg      <= bsel_sync_reg[1]; // RQ21
			strap_done_reg <= 1'b1;
		end
	end
	// first boot has no latched strap yet, so read the synced pin directly
	assign boot_strap = strap_done_reg ? strap_reg : bsel_sync_reg[1];
	assign boot_ind   = state_reg == power_mode_pkg::ST_BOOT && boot_strap &&
		boot_cnt_reg >= CNT_W'(IND_OFS) && boot_cnt_reg < CNT_W'(PULSE_CYCLES + IND_OFS); // RQ10

	// line low debounce for hibernate entry
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			hib_cnt_reg <= '0;
		else if (clk_en) begin
			// own pulses would otherwise look like a host hibernate request
			if (line_s || drive_reg)
				hib_cnt_reg <= '0;
			else if (hib_cnt_reg != CNT_W'(HIB_CYCLES))
				hib_cnt_reg <= hib_cnt_reg + CNT_W'(1);
		end
	end
	assign hib_low_done = (hib_cnt_reg == CNT_W'(HIB_CYCLES - 1)) && !line_s; // RQ18

	// boot timer; also drives the boot indicator
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			boot_cnt_reg <= '0;
		else if (clk_en) begin
			if (state_reg == power_mode_pkg::ST_BOOT)
				boot_cnt_reg <= boot_cnt_reg + CNT_W'(1);
			else
				boot_cnt_reg <= '0;
		end
	end

	// mode state machine
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg  <= power_mode_pkg::ST_BOOT;
			active_reg <= 1'b0;
			conv_start <= 1'b0;
		end else if (clk_en) begin
			conv_start <= 1'b0;
			unique case (state_reg)
			power_mode_pkg::ST_BOOT: begin
				if (boot_cnt_reg == CNT_W'(BOOT_CYCLES - 1)) begin
					if (!strap_reg)
						state_reg <= power_mode_pkg::ST_STANDBY;
					else if (line_s) begin
						state_reg  <= power_mode_pkg::ST_WAKE; // RQ5
						active_reg <= 1'b1; // RQ5
					end else
						state_reg <= power_mode_pkg::ST_HIB; // RQ11
				end
			end
			power_mode_pkg::ST_STANDBY: begin
				if (strap_reg && hib_low_done)
					state_reg <= power_mode_pkg::ST_HIB; // RQ18
				else if (hib_wr)
					state_reg <= power_mode_pkg::ST_HIB; // RQ19
				else if (active_wr && active_wr_val) begin
					active_reg <= 1'b1; // RQ4 RQ6
					state_reg  <= power_mode_pkg::ST_WAKE;
				end else if (!strap_reg && pin_two_function_select)
					state_reg <= power_mode_pkg::ST_TRIG; // RQ20 RQ2
			end
			power_mode_pkg::ST_TRIG: begin
				if (!pin_two_function_select)
					state_reg <= power_mode_pkg::ST_STANDBY; // RQ20
				else if (trig_rise) begin
					conv_start <= 1'b1; // RQ1
					state_reg  <= power_mode_pkg::ST_MEAS; // RQ1
				end
			end
			power_mode_pkg::ST_MEAS: begin
				// no timeout: a measurement that never finishes holds the state
				if (meas_done)
					state_reg <= power_mode_pkg::ST_TRIG; // RQ3
			end
			power_mode_pkg::ST_WAKE, power_mode_pkg::ST_SLEEP: begin
				if (strap_reg && hib_low_done) begin
					active_reg <= 1'b0; // RQ7
					state_reg  <= power_mode_pkg::ST_HIB; // RQ18
				end else if (hib_wr) begin
					active_reg <= 1'b0;
					state_reg  <= power_mode_pkg::ST_HIB;
				end else if (active_wr && !active_wr_val) begin
					active_reg <= 1'b0; // RQ4 RQ7
					state_reg  <= power_mode_pkg::ST_STANDBY;
				end else if (state_reg == power_mode_pkg::ST_SLEEP && auto_wake_sleep_event)
					state_reg <= power_mode_pkg::ST_WAKE; // RQ9
				else if (state_reg == power_mode_pkg::ST_WAKE && auto_sleep_count != '0 &&
					auto_sleep_count_reg == auto_sleep_count)
					state_reg <= power_mode_pkg::ST_SLEEP; // RQ8
			end
			power_mode_pkg::ST_HIB: begin
				// one-wire exits on line high; serial path only by wake pin toggle
				if (strap_reg ? line_s : wake_toggle)
					state_reg <= power_mode_pkg::ST_BOOT; // RQ12 RQ19
			end
			default: state_reg <= power_mode_pkg::ST_BOOT;
			endcase
		end
	end

	// auto-sleep timer, restarted by any enabled event
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			auto_sleep_count_reg <= '0;
		else if (clk_en) begin
			// counting stops at the target so the compare cannot be skipped
			if (state_reg != power_mode_pkg::ST_WAKE || auto_wake_sleep_event)
				auto_sleep_count_reg <= '0; // RQ8
			else if (sample_tick && auto_sleep_count_reg != auto_sleep_count)
				auto_sleep_count_reg <= auto_sleep_count_reg + ASLP_W'(1);
		end
	end

	// threshold window opens when the boot indicator is released
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			win_open_reg <= 1'b0;
			win_cnt_reg  <= '0;
			low_cnt_reg  <= '0;
			thr_reg      <= `THR_DEFAULT;
		end else if (clk_en) begin
			// opens as the indicator ends, even when boot ends it early
			if (boot_ind_reg && !boot_ind) begin
				win_open_reg <= 1'b1; // RQ13
				win_cnt_reg  <= '0;
				low_cnt_reg  <= '0;
				thr_reg      <= `THR_DEFAULT; // RQ14
			end else if (win_open_reg) begin
				win_cnt_reg <= win_cnt_reg + CNT_W'(1);
				if (win_cnt_reg == CNT_W'(WIN_CYCLES - 1))
					win_open_reg <= 1'b0; // pulse still low here is dropped, RQ15
				if (!line_s)
					low_cnt_reg <= low_cnt_reg + CNT_W'(1);
				else if (!line_prev_reg && low_cnt_reg != '0) begin
					thr_reg     <= width_code(low_cnt_reg); // RQ15
					low_cnt_reg <= '0;
				end
			end
		end
	end

	// width classifier, times in ns against cycle count
	function automatic logic [1:0] width_code(input logic [CNT_W-1:0] cyc);
		longint ns;
		ns = longint'(cyc) * `CLK_PERIOD_NS;
		if (ns >= `THR1_MIN_NS && ns <= `THR1_MAX_NS)
			width_code = 2'h1;
		else if (ns >= `THR2_MIN_NS && ns <= `THR2_MAX_NS)
			width_code = 2'h2;
		else if (ns >= `THR3_MIN_NS && ns <= `THR3_MAX_NS)
			width_code = 2'h3;
		else
			width_code = `THR_DEFAULT;
	endfunction

	// wake and sleep both sample and may signal motion
	function automatic logic in_motion_mode(input power_mode_pkg::mode_t st);
		in_motion_mode = st == power_mode_pkg::ST_WAKE || st == power_mode_pkg::ST_SLEEP;
	endfunction

	// motion pulse timer; boot indicator and motion pulse share the open drain
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mot_cnt_reg  <= '0;
			drive_reg    <= 1'b0;
			boot_ind_reg <= 1'b0;
		end else if (clk_en) begin
			boot_ind_reg <= boot_ind;
			if (state_reg == power_mode_pkg::ST_BOOT && boot_strap)
				drive_reg <= boot_ind; // RQ10
			else if (mot_cnt_reg != '0) begin
				mot_cnt_reg <= mot_cnt_reg - CNT_W'(1);
				drive_reg   <= mot_cnt_reg != CNT_W'(1);
			end else if (strap_reg && !win_open_reg && motion_detected &&
				in_motion_mode(state_reg)) begin
				mot_cnt_reg <= CNT_W'(MOT_CYCLES); // RQ16
				drive_reg   <= 1'b1; // RQ16
			end else
				drive_reg <= 1'b0;
		end
	end

	assign motion_line_out = 1'b0;
	assign motion_line_oe  = drive_reg;
	assign active_bit      = active_reg;
	assign threshold_code  = thr_reg;
	assign mode_state      = state_reg;
	assign sample_enable   = in_motion_mode(state_reg); // RQ16
	// serial port stays up in every powered mode, hibernate and boot are the only exceptions
	assign serial_enable   = state_reg != power_mode_pkg::ST_HIB &&
		state_reg != power_mode_pkg::ST_BOOT; // RQ17
endmodule

// >>> verilog/power_mode_cfg.svh
// timing and field constants for the power mode sequencer
`ifndef POWER_MODE_CFG_SVH
`define POWER_MODE_CFG_SVH
`define CLK_PERIOD_NS       10
`define BOOT_TIME_US        1000
`define BOOT_CYCLES         ((`BOOT_TIME_US * 1000) / `CLK_PERIOD_NS)
`define BOOT_PULSE_US       1000
`define BOOT_PULSE_CYCLES   ((`BOOT_PULSE_US * 1000) / `CLK_PERIOD_NS)
`define WIN_TIME_US         10000
`define WIN_CYCLES          ((`WIN_TIME_US * 1000) / `CLK_PERIOD_NS)
`define HIB_TIME_US         10000
`define HIB_CYCLES          ((`HIB_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MOT_PULSE_US        1000
`define MOT_PULSE_CYCLES    ((`MOT_PULSE_US * 1000) / `CLK_PERIOD_NS)
`define THR1_MIN_NS         562500
`define THR1_MAX_NS         883000
`define THR2_MIN_NS         1125000
`define THR2_MAX_NS         1570000
`define THR3_MIN_NS         2250000
`define THR3_MAX_NS         2950000
`define THR_DEFAULT         2'h0
`endif

// >>> verilog/power_mode_pkg.sv
// types for the power mode sequencer
package power_mode_pkg;
	typedef enum logic [6:0] {
		ST_BOOT    = 7'h01,
		ST_STANDBY = 7'h02,
		ST_WAKE    = 7'h04,
		ST_SLEEP   = 7'h08,
		ST_TRIG    = 7'h10,
		ST_HIB     = 7'h20,
		ST_MEAS    = 7'h40
	} mode_t;
endpackage
